// File: design/dmaseq_core.sv
// Transfer-cycle sequencer: bus hold, channel grant, S1..S4 with wait states and strobes
`timescale 1ns/1ps
`include "dmaseq_map.svh"
// Notes on behaviour
// RULE1: idle does nothing; strobes and acknowledges stay inactive.
// RULE2: any request while idle moves to S0.
// RULE3: S0 raises hold request and waits for the grant.
// RULE4: S0 samples requests and resolves fixed or rotating priority.
// RULE5: after grant, winning channel's active-low acknowledge goes low.
// RULE6: peripheral holds its request until acknowledge (burst: until terminal count).
// RULE7: a cycle is S1 to S4, one clock each unless waiting.
// RULE8: no ready by S3 inserts wait states until ready, then S4.
// RULE9: ready is sampled at S3 and every wait state.
// RULE10: extended write or verify mode skips wait states.
// RULE11: grant loss finishes current cycle, then idles until regranted.
// RULE12: write transfer: I/O read at S2, memory write at S3.
// RULE13: read transfer: memory read at S2, I/O write at S3.
// RULE14: verify transfers produce no read or write strobes.
// RULE15: hold request follows whether any channel request is active.
// RULE16: upper-address latch strobe pulses during S1 only and is low again in S2.
// RULE17: low address byte on address pins, high byte on data pins.
// RULE18: verify still takes bus, acknowledges and addresses normally.
// RULE19: bus kept while the channel requests, until terminal count.
// RULE20: after S4 return to idle if nothing pending, else next cycle.
module dmaseq_core
  import dmaseq_pkg::*;
#(
  parameter int NCH = 4
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   resetn_in,
  input  wire logic [NCH-1:0]         channel_request_in,
  input  wire logic                   bus_hold_grant_in,
  input  wire logic                   ready_in,
  input  wire logic [1:0]             mode_in,
  input  wire logic                   rotate_priority_in,
  input  wire logic                   extended_write_in,
  input  wire logic                   terminal_count_in,
  input  wire logic [15:0]            address_in,
  output logic                        bus_hold_request_out,
  output logic [NCH-1:0]              channel_acknowledge_n_out,
  output logic                        memory_read_strobe_n_out,
  output logic                        memory_write_strobe_n_out,
  output logic                        io_read_strobe_n_out,
  output logic                        io_write_strobe_n_out,
  output logic                        address_strobe_out,
  output logic [7:0]                  address_low_out,
  output logic [7:0]                  data_high_address_out,
  output logic                        data_drive_n_out,
  output logic [$clog2(NCH)-1:0]      active_chan_out,
  output logic [2:0]                  state_out
);
  localparam int CW = $clog2(NCH);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dmaseq_state_e   state, next_state;
  logic [CW-1:0]   chan, next_chan;
  logic [1:0]      mode, next_mode;
  logic            hold, next_hold;
  logic [NCH-1:0]  ack_n, next_ack_n;
  dmaseq_strobes_s stb, next_stb;
  logic            astb, next_astb;
  logic [7:0]      alo, next_alo;
  logic [7:0]      ahi, next_ahi;
  logic            dbn, next_dbn;
  logic            any_req;
  logic [CW-1:0]   winner;
  logic            served;

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  // Winner committed at the grant, so rotation advances once per cycle
  assign served = (state == DMASEQ_S0) && bus_hold_grant_in && any_req;

  dmaseq_arbiter #(.NCH(NCH)) u_arb (
    .sys_clk_in     (sys_clk_in),
    .resetn_in      (resetn_in),
    .req_in         (channel_request_in),
    .rotate_in      (rotate_priority_in),
    .served_in      (served),
    .served_chan_in (winner),
    .any_out        (any_req),
    .win_out        (winner)
  );

  // Wait states only when a strobe needs the slow side; verify and extended write skip them
  function automatic logic needs_wait(input logic [1:0] m, input logic ext);
    needs_wait = (m != `DMASEQ_MODE_VERIFY) && !ext; // RULE10
  endfunction : needs_wait

  // ----------------------------------------------------------------
  // Next-state and output computation
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_chan  = chan;
    next_mode  = mode;
    next_hold  = any_req;                                 // RULE15
    next_ack_n = ack_n;
    next_stb   = stb;
    next_astb  = 1'b0;
    next_alo   = alo;
    next_ahi   = ahi;
    next_dbn   = 1'b1;
    unique case (state)
      DMASEQ_IDLE: begin
        next_ack_n = `DMASEQ_ACK_IDLE;                    // RULE1
        next_stb   = '{default: `DMASEQ_STROBE_IDLE};     // RULE1
        if (any_req) begin
          next_state = DMASEQ_S0;                         // RULE2
        end
      end
      DMASEQ_S0: begin
        if (!any_req) begin
          next_state = DMASEQ_IDLE;
        end else if (bus_hold_grant_in) begin             // RULE3
          next_chan         = winner;                     // RULE4
          next_mode         = mode_in;
          next_ack_n        = `DMASEQ_ACK_IDLE;
          next_ack_n[winner] = 1'b0;                      // RULE5 RULE18
          next_alo          = address_in[`DMASEQ_ADDR_LO_MSB:0];  // RULE17
          next_ahi          = address_in[15:`DMASEQ_ADDR_HI_LSB]; // RULE17
          next_dbn          = 1'b0;
          next_astb         = 1'b1;                       // RULE16
          next_state        = DMASEQ_S1;                  // RULE7
        end
      end
      DMASEQ_S1: begin
        // Read strobes start S2; extended write pulls the write early too
        if (mode == `DMASEQ_MODE_WRITE) begin
          next_stb.io_read_strobe_n = 1'b0;               // RULE12
          if (extended_write_in) begin
            next_stb.memory_write_strobe_n = 1'b0;
          end
        end else if (mode == `DMASEQ_MODE_READ) begin
          next_stb.memory_read_strobe_n = 1'b0;           // RULE13
          if (extended_write_in) begin
            next_stb.io_write_strobe_n = 1'b0;
          end
        end                                                // RULE14
        next_state = DMASEQ_S2;                           // RULE16
      end
      DMASEQ_S2: begin
        if (mode == `DMASEQ_MODE_WRITE) begin
          next_stb.memory_write_strobe_n = 1'b0;          // RULE12
        end else if (mode == `DMASEQ_MODE_READ) begin
          next_stb.io_write_strobe_n = 1'b0;              // RULE13
        end
        next_state = DMASEQ_S3;
      end
      DMASEQ_S3, DMASEQ_SW: begin
        // Ready sampled on this edge decides advance
        if (ready_in || !needs_wait(mode, extended_write_in)) begin // RULE9
          next_state = DMASEQ_S4;
        end else begin
          next_state = DMASEQ_SW;                         // RULE8
        end
      end
      DMASEQ_S4: begin
        next_stb   = '{default: `DMASEQ_STROBE_IDLE};
        next_ack_n = `DMASEQ_ACK_IDLE;
        // Lost grant or terminal count ends the run; otherwise keep going while requests remain
        if (!bus_hold_grant_in || !any_req || terminal_count_in) begin // RULE11 RULE19 RULE20
          next_state = DMASEQ_IDLE;
        end else begin
          next_state = DMASEQ_S0;                         // RULE19
        end
      end
      default: begin
        next_state = DMASEQ_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state <= DMASEQ_IDLE;
      chan  <= '0;
      mode  <= `DMASEQ_MODE_VERIFY;
      hold  <= 1'b0;
      ack_n <= `DMASEQ_ACK_IDLE;
      stb   <= '{default: `DMASEQ_STROBE_IDLE};
      astb  <= 1'b0;
      alo   <= `DMASEQ_ADDR_RESET;
      ahi   <= '0;
      dbn   <= 1'b1;
    end else begin
      state <= next_state;
      chan  <= next_chan;
      mode  <= next_mode;
      hold  <= next_hold;
      ack_n <= next_ack_n;
      stb   <= next_stb;
      astb  <= next_astb;
      alo   <= next_alo;
      ahi   <= next_ahi;
      dbn   <= next_dbn;
    end
  end

  assign bus_hold_request_out      = hold;
  assign channel_acknowledge_n_out = ack_n;
  assign memory_read_strobe_n_out  = stb.memory_read_strobe_n;
  assign memory_write_strobe_n_out = stb.memory_write_strobe_n;
  assign io_read_strobe_n_out      = stb.io_read_strobe_n;
  assign io_write_strobe_n_out     = stb.io_write_strobe_n;
  assign address_strobe_out        = astb;
  assign address_low_out           = alo;
  assign data_high_address_out     = ahi;
  assign data_drive_n_out          = dbn;
  assign active_chan_out           = chan;
  assign state_out                 = state;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_grant;
    state == DMASEQ_S0 && bus_hold_grant_in && any_req;
  endsequence
  sequence s_walk;
    state == DMASEQ_S1 ##1 state == DMASEQ_S2 ##1 state == DMASEQ_S3;
  endsequence

  property p_idle_quiet;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      $past(state) == DMASEQ_IDLE && state == DMASEQ_IDLE |-> ack_n == `DMASEQ_ACK_IDLE && &stb;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity in idle"); // RULE1
  property p_idle_to_s0;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      state == DMASEQ_IDLE && any_req |=> state == DMASEQ_S0;
  endproperty
  a_idle_to_s0: assert property (p_idle_to_s0) else $error("request did not start a cycle"); // RULE2
  property p_s0_wait;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      state == DMASEQ_S0 && !bus_hold_grant_in |=> state inside {DMASEQ_S0, DMASEQ_IDLE};
  endproperty
  a_s0_wait: assert property (p_s0_wait) else $error("left S0 without grant"); // RULE3
  property p_ack_winner;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      s_grant |=> ack_n == ~(NCH'(1) << $past(winner)) && state == DMASEQ_S1;
  endproperty
  a_ack_winner: assert property (p_ack_winner) else $error("wrong acknowledge"); // RULE5
  property p_walk;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      s_grant |=> s_walk;
  endproperty
  a_walk: assert property (p_walk) else $error("cycle states out of order"); // RULE7
  property p_wait;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      state inside {DMASEQ_S3, DMASEQ_SW} && !ready_in && needs_wait(mode, extended_write_in)
        |=> state == DMASEQ_SW;
  endproperty
  a_wait: assert property (p_wait) else $error("missing wait state"); // RULE8
  property p_ready;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      state inside {DMASEQ_S3, DMASEQ_SW} && ready_in |=> state == DMASEQ_S4;
  endproperty
  a_ready: assert property (p_ready) else $error("ready ignored"); // RULE9
  property p_write_strobes;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      state == DMASEQ_S1 && mode == `DMASEQ_MODE_WRITE |=> !stb.io_read_strobe_n ##1 !stb.memory_write_strobe_n;
  endproperty
  a_write_strobes: assert property (p_write_strobes) else $error("write strobes late"); // RULE12
  property p_read_strobes;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      state == DMASEQ_S1 && mode == `DMASEQ_MODE_READ |=> !stb.memory_read_strobe_n ##1 !stb.io_write_strobe_n;
  endproperty
  a_read_strobes: assert property (p_read_strobes) else $error("read strobes late"); // RULE13
  property p_verify_quiet;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      mode == `DMASEQ_MODE_VERIFY && state != DMASEQ_IDLE && $past(state) != DMASEQ_IDLE |-> &stb;
  endproperty
  a_verify_quiet: assert property (p_verify_quiet) else $error("strobe in verify"); // RULE14

  property p_hold;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      1'b1 |=> hold == $past(any_req);
  endproperty
  a_hold: assert property (p_hold) else $error("hold request mismatch"); // RULE15

  property p_grant_loss;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      state == DMASEQ_S4 && !bus_hold_grant_in |=> state == DMASEQ_IDLE;
  endproperty
  a_grant_loss: assert property (p_grant_loss) else $error("ran on without grant"); // RULE11
endmodule : dmaseq_core

// File: design/dmaseq_map.svh
// Constants for the transfer-cycle sequencer: encodings, field positions, reset values, timing
`ifndef DMASEQ_MAP_SVH
`define DMASEQ_MAP_SVH
// ----------------------------------------------------------------
// Transfer modes
// ----------------------------------------------------------------
`define DMASEQ_MODE_VERIFY  2'h0
`define DMASEQ_MODE_WRITE   2'h1
`define DMASEQ_MODE_READ    2'h2
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DMASEQ_STROBE_IDLE  1'h1
`define DMASEQ_ACK_IDLE     4'hf
`define DMASEQ_CHAN_RESET   2'h3
`define DMASEQ_ADDR_RESET   8'h00
// ----------------------------------------------------------------
// Address split: low byte on address pins, high byte on data pins
// ----------------------------------------------------------------
`define DMASEQ_ADDR_LO_MSB  7
`define DMASEQ_ADDR_HI_LSB  8
// ----------------------------------------------------------------
// Timing: one state lasts one clock period
// ----------------------------------------------------------------
`define DMASEQ_CLK_PERIOD_NS 10
`define DMASEQ_STATE_NS      10
`define DMASEQ_STATE_CYCLES  ((`DMASEQ_STATE_NS + `DMASEQ_CLK_PERIOD_NS - 1) / `DMASEQ_CLK_PERIOD_NS)
`endif

// File: design/dmaseq_pkg.sv
// Types shared by the transfer-cycle sequencer files
package dmaseq_pkg;
  typedef enum logic [2:0] {
    DMASEQ_IDLE = 3'h0,
    DMASEQ_S0   = 3'h1,
    DMASEQ_S1   = 3'h2,
    DMASEQ_S2   = 3'h3,
    DMASEQ_S3   = 3'h4,
    DMASEQ_SW   = 3'h5,
    DMASEQ_S4   = 3'h6
  } dmaseq_state_e;

  typedef struct packed {
    logic memory_read_strobe_n;
    logic memory_write_strobe_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
  } dmaseq_strobes_s;
endpackage : dmaseq_pkg

// File: design/dmaseq_arbiter.sv
// Channel priority resolver with fixed or rotating order
`timescale 1ns/1ps
`include "dmaseq_map.svh"
module dmaseq_arbiter
  import dmaseq_pkg::*;
#(
  parameter int NCH = 4
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   resetn_in,
  input  wire logic [NCH-1:0]         req_in,
  input  wire logic                   rotate_in,
  input  wire logic                   served_in,
  input  wire logic [$clog2(NCH)-1:0] served_chan_in,
  output logic                        any_out,
  output logic [$clog2(NCH)-1:0]      win_out
);
  localparam int CW = $clog2(NCH);
  logic [CW-1:0] last;
  logic [CW-1:0] next_last;

  // Rotation remembers the last served channel so it drops to lowest priority
  always_comb begin
    next_last = last;
    if (served_in) begin
      next_last = served_chan_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      last <= `DMASEQ_CHAN_RESET;
    end else begin
      last <= next_last;
    end
  end

  // Search starts after the last served channel in rotating mode, at channel 0 otherwise
  always_comb begin
    logic [CW-1:0] idx;
    logic          found;
    idx     = '0;
    found   = 1'b0;
    win_out = '0;
    for (int k = 0; k < NCH; k++) begin
      idx = rotate_in ? CW'(int'(last) + 1 + k) : CW'(k);
      if (!found && req_in[idx]) begin
        found   = 1'b1;
        win_out = idx;
      end
    end
    any_out = |req_in;
  end
endmodule : dmaseq_arbiter

// File: tb/dmaseq_host_model.sv
// Host bus arbitration and memory ready model facing the sequencer
`timescale 1ns/1ps
module dmaseq_host_model
  import dmaseq_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       bus_hold_request_in,
  input  wire logic [3:0] channel_acknowledge_n_in,
  input  wire logic [3:0] grant_delay_in,
  input  wire logic [3:0] wait_count_in,
  input  wire logic       revoke_in,
  output logic            bus_hold_grant_out,
  output logic            ready_out
);
  logic [3:0] gcnt;
  logic [3:0] acnt;
  // ----------------------------------------------------------------
  // Bus grant
  // ----------------------------------------------------------------
  // Grant trails the hold request by a set delay; revoke steals the bus back
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || !bus_hold_request_in || revoke_in) begin
      gcnt               <= 4'h0;
      bus_hold_grant_out <= 1'b0;
    end else begin
      if (gcnt != 4'hf) begin
        gcnt <= gcnt + 4'h1;
      end
      bus_hold_grant_out <= (gcnt >= grant_delay_in);
    end
  end
  // ----------------------------------------------------------------
  // Slow memory
  // ----------------------------------------------------------------
  // Cycles since acknowledge fell; S3 is the third such cycle
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || (&channel_acknowledge_n_in)) begin
      acnt <= 4'h0;
    end else if (acnt != 4'hf) begin
      acnt <= acnt + 4'h1;
    end
  end
  // Ready withheld for the requested number of wait states, low when unselected
  assign ready_out = ({1'b0, acnt} >= ({1'b0, wait_count_in} + 5'h02));
endmodule : dmaseq_host_model

// File: tb/dmaseq_core_tb.sv
// Self-checking bench for the transfer-cycle sequencer
`timescale 1ns/1ps
`include "dmaseq_map.svh"
module dmaseq_core_tb
  import dmaseq_pkg::*;
;
  logic            clk;
  logic            rstn;
  logic [3:0]      req;
  logic [1:0]      mode;
  logic            rot;
  logic            ext;
  logic            tc;
  logic [15:0]     addr;
  logic [3:0]      gdel;
  logic [3:0]      wcnt;
  logic            revoke;
  logic            grant;
  logic            rdy;
  logic            hold;
  logic [3:0]      ack;
  wire  dmaseq_strobes_s str;
  logic            astb;
  logic [7:0]      alo;
  logic [7:0]      dhi;
  logic            dbn;
  logic [1:0]      ach;
  logic [2:0]      st;
  int              err_total;
  int              check_count;
  int              cyc;

  dmaseq_core #(.NCH(4)) i_dut (
    .sys_clk_in(clk), .resetn_in(rstn), .channel_request_in(req), .bus_hold_grant_in(grant),
    .ready_in(rdy), .mode_in(mode), .rotate_priority_in(rot), .extended_write_in(ext),
    .terminal_count_in(tc), .address_in(addr), .bus_hold_request_out(hold),
    .channel_acknowledge_n_out(ack), .memory_read_strobe_n_out(str.memory_read_strobe_n),
    .memory_write_strobe_n_out(str.memory_write_strobe_n), .io_read_strobe_n_out(str.io_read_strobe_n),
    .io_write_strobe_n_out(str.io_write_strobe_n), .address_strobe_out(astb), .address_low_out(alo),
    .data_high_address_out(dhi), .data_drive_n_out(dbn), .active_chan_out(ach), .state_out(st));

  dmaseq_host_model i_host (
    .sys_clk_in(clk), .resetn_in(rstn), .bus_hold_request_in(hold), .channel_acknowledge_n_in(ack),
    .grant_delay_in(gdel), .wait_count_in(wcnt), .revoke_in(revoke), .bus_hold_grant_out(grant),
    .ready_out(rdy));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // Strobe pattern a state should show; extended write pulls the write edge into S2
  function automatic dmaseq_strobes_s exp_str(input logic [2:0] s, input logic [1:0] m, input logic e);
    logic rd;
    logic wr;
    rd = (s >= DMASEQ_S2) && (s <= DMASEQ_S4);
    wr = e ? rd : ((s >= DMASEQ_S3) && (s <= DMASEQ_S4));
    exp_str = '1;
    if (m == `DMASEQ_MODE_WRITE) begin
      exp_str.io_read_strobe_n = !rd;
      exp_str.memory_write_strobe_n = !wr;
    end else if (m == `DMASEQ_MODE_READ) begin
      exp_str.memory_read_strobe_n = !rd;
      exp_str.io_write_strobe_n = !wr;
    end
  endfunction : exp_str

  task automatic wait_st(input logic [2:0] s);
    int k;
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      if (st === s) break;
    end
    chk(st === s, "state not reached");
  endtask : wait_st

  // Runs n cycles; the peripheral drops its request once the last cycle is acknowledged
  task automatic run(input logic [3:0] rq, input logic [1:0] md, input logic ex, input logic [3:0] w,
                     input logic [3:0] gd, input logic rt, input logic [1:0] c0, input logic [1:0] c1,
                     input int n);
    int i;
    int k;
    int sw;
    int ew;
    logic [1:0] ch;
    logic [15:0] a;
    a = {rq, 2'h1, md, w, gd};
    ew = (md == `DMASEQ_MODE_VERIFY || ex) ? 0 : int'(w);
    @(posedge clk);
    req <= rq;
    mode <= md;
    ext <= ex;
    wcnt <= w;
    gdel <= gd;
    rot <= rt;
    addr <= a;
    for (i = 0; i < n; i++) begin
      ch = (i == 0) ? c0 : c1;
      k = 0;
      @(negedge clk);
      while (st !== DMASEQ_S1 && k < 40) begin
        chk(ack === 4'hf && astb === 1'b0, "early acknowledge");
        if (st === DMASEQ_S0) chk(hold === 1'b1, "no hold request in S0");
        k++;
        @(negedge clk);
      end
      chk(i > 0 || k == int'(gd) + 3, "S0 not held until grant");
      chk(ack === ~(4'h1 << ch) && ach === ch, "wrong channel acknowledged");
      chk(astb === 1'b1 && dbn === 1'b0, "no upper address latch pulse");
      chk({dhi, alo} === a, "address split wrong");
      sw = 0;
      k = 0;
      @(posedge clk);
      if (i == n - 1) req <= 4'h0;
      @(negedge clk);
      while (st !== DMASEQ_S4 && k < 30) begin
        chk(str === exp_str(st, md, ex) && ack === ~(4'h1 << ch), "strobes wrong");
        chk(astb === 1'b0 && dbn === 1'b1, "latch strobe too long");
        if (st === DMASEQ_SW) sw++;
        k++;
        @(negedge clk);
      end
      chk(str === exp_str(st, md, ex) && ack === ~(4'h1 << ch), "S4 strobes wrong");
      chk(sw == ew && k == ew + 2, "wait states wrong");
    end
    @(negedge clk);
    chk(st === DMASEQ_IDLE && ack === 4'hf && str === '1, "no return to idle");
    repeat (2) @(negedge clk);
    chk(hold === 1'b0 && st === DMASEQ_IDLE, "hold request kept");
    $display("test done mode %0d chan %0d cycles %0d", md, c0, n);
  endtask : run

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs roughly a hundred cycles; a hang is cut well before it drags
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    {rstn, req, mode, rot, ext, tc, revoke} = '0;
    addr = 16'h0000;
    gdel = 4'h0;
    wcnt = 4'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(negedge clk);
    chk(st === DMASEQ_IDLE && hold === 1'b0 && ack === 4'hf && str === '1 && astb === 1'b0
        && dbn === 1'b1, "idle outputs active");
    run(4'h4, `DMASEQ_MODE_WRITE, 1'b0, 4'h0, 4'h0, 1'b0, 2'h2, 2'h2, 1);
    run(4'h3, `DMASEQ_MODE_READ, 1'b0, 4'h2, 4'h3, 1'b1, 2'h0, 2'h1, 2);
    run(4'ha, `DMASEQ_MODE_WRITE, 1'b1, 4'h3, 4'h1, 1'b0, 2'h1, 2'h1, 1);
    run(4'h8, `DMASEQ_MODE_VERIFY, 1'b0, 4'h3, 4'h0, 1'b0, 2'h3, 2'h3, 2);
    // Request withdrawn while still waiting for the bus
    @(posedge clk);
    req <= 4'h2;
    gdel <= 4'hf;
    repeat (4) @(posedge clk);
    req <= 4'h0;
    repeat (3) @(negedge clk);
    chk(st === DMASEQ_IDLE && ack === 4'hf && hold === 1'b0, "withdrawn request");
    $display("test done withdrawn request");
    // Bus taken back mid-cycle: cycle completes, nothing more until regranted
    @(posedge clk);
    req <= 4'h4;
    gdel <= 4'h0;
    wait_st(DMASEQ_S2);
    @(posedge clk);
    revoke <= 1'b1;
    wait_st(DMASEQ_S4);
    @(negedge clk);
    chk(st === DMASEQ_IDLE && ack === 4'hf, "cycle ran on without bus");
    repeat (5) begin
      @(negedge clk);
      chk(ack === 4'hf && st !== DMASEQ_S1, "cycle without bus");
    end
    @(posedge clk);
    revoke <= 1'b0;
    wait_st(DMASEQ_S1);
    // Terminal count ends the run even though the request still stands
    @(posedge clk);
    tc <= 1'b1;
    wait_st(DMASEQ_S4);
    @(negedge clk);
    chk(st === DMASEQ_IDLE, "terminal count did not end the run");
    @(posedge clk);
    tc <= 1'b0;
    req <= 4'h0;
    wait_st(DMASEQ_IDLE);
    $display("test done bus revoke");
    test_done();
  end
endmodule : dmaseq_core_tb
